// ### sdc_core.sv
// Purpose: command decode, bank tracking, burst and data path of an SDRAM
// Assumes: pins synchronous to core_clk; array is a small modelled memory
// Notes: memory depth is a parameter, address folded into it
`timescale 1ns/1ns
`default_nettype none
module sdc_core #(
    parameter int MEM_AW = 10
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Command pins
    input wire logic clk_gate,
    input wire sdc_pkg::sdc_cmd_t cmd,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [sdc_pkg::ADDR_W-1:0] addr,
    // Data pins
    input wire logic [sdc_pkg::LANES-1:0] byte_mask,
    input wire logic [sdc_pkg::DATA_W-1:0] dq_in,
    output logic [sdc_pkg::DATA_W-1:0] dq_out,
    output logic [sdc_pkg::LANES-1:0] dq_oe,
    // Status
    output logic [sdc_pkg::BANKS-1:0] bank_open,
    output logic self_refresh_active,
    output logic [sdc_pkg::ADDR_W-1:0] refresh_row
);
    // ==========================================================
    // Declarations
    localparam int AW = sdc_pkg::ADDR_W;
    logic [AW-1:0] operating_mode_setup; // Mode register
    sdc_pkg::sdc_bank_t banks [sdc_pkg::BANKS]; // Row state per bank
    logic [sdc_pkg::DATA_W-1:0] mem [2**MEM_AW]; // Modelled array
    sdc_pkg::sdc_state_t state;
    logic [1:0] bank_sel;
    logic [3:0] cmd_code;
    logic [7:0] burst_left; // Remaining beats, current one included
    logic [7:0] col; // Current column
    logic [7:0] col_base; // Start column for wrap
    logic [1:0] cur_bank;
    logic auto_pre; // Close row at burst end
    logic [2:0] burst_length;
    logic [2:0] read_latency;
    logic write_burst_select_bit;
    logic [7:0] bl_beats;
    logic [7:0] wrap_mask;
    logic [7:0] next_col;
    logic cmd_live;
    logic [3:0] rd_pipe; // Read beat valid per delay stage
    logic [MEM_AW-1:0] rd_addr_pipe [4];
    logic [sdc_pkg::LANES-1:0] mask_d1, mask_d2; // Read mask delay
    logic burst_end;
    // All checks below run on the one core clock
    default clocking dflt_cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    assign bank_sel = {bank_select_high, bank_select_low};
    assign cmd_code = cmd;
    // Commands only count with gate high; self refresh handled apart
    assign cmd_live = !cmd.cs_n && clk_gate
        && state != sdc_pkg::ST_SELF;
    assign burst_length = operating_mode_setup[sdc_pkg::MR_BL_LO +: 3];
    assign read_latency = operating_mode_setup[sdc_pkg::MR_CL_LO +: 3];
    assign write_burst_select_bit = operating_mode_setup[sdc_pkg::MR_WB];
    assign self_refresh_active = (state == sdc_pkg::ST_SELF);

    // Beats per burst from the length code
    always_comb begin
        case (burst_length)
            sdc_pkg::BL_2: bl_beats = 8'h02;
            sdc_pkg::BL_4: bl_beats = 8'h04;
            sdc_pkg::BL_8: bl_beats = 8'h08;
            sdc_pkg::BL_PAGE: bl_beats = 8'h00; // Runs until stopped
            default: bl_beats = 8'h01;
        endcase
        wrap_mask = (bl_beats == 8'h00) ? 8'hff : 8'(bl_beats - 8'h01);
    end

    // Sequential or interleaved step within the wrap block
    always_comb begin
        if (operating_mode_setup[sdc_pkg::MR_BT]
                && burst_length != sdc_pkg::BL_PAGE) begin
            // Offset of the next beat, counted from the start column
            next_col = (col_base & ~wrap_mask)
                | ((col_base ^ 8'(bl_beats - burst_left + 8'h01))
                & wrap_mask);
        end else begin
            next_col = (col & ~wrap_mask) | (8'(col + 8'h01) & wrap_mask);
        end
    end
    assign burst_end = (burst_left == 8'h01) && bl_beats != 8'h00;

    // ==========================================================
    // Mode register load, only in normal operation
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            operating_mode_setup <= sdc_pkg::MR_RESET;
        end else if (cmd_live && cmd_code == sdc_pkg::CMD_MRL) begin
            // Op-code straight from the address pins
            operating_mode_setup <= addr;
        end
    end

    // ==========================================================
    // Burst sequencer and self refresh
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= sdc_pkg::ST_IDLE;
            burst_left <= 8'h00;
            col <= 8'h00;
            col_base <= 8'h00;
            cur_bank <= 2'h0;
            auto_pre <= 1'b0;
        end else if (state == sdc_pkg::ST_SELF) begin
            // Only the gate matters until it rises
            if (clk_gate) begin
                state <= sdc_pkg::ST_IDLE;
            end
        end else if (!cmd.cs_n && !clk_gate && cmd_code == sdc_pkg::CMD_REF) begin
            state <= sdc_pkg::ST_SELF;
            burst_left <= 8'h00;
        end else if (cmd_live && (cmd_code == sdc_pkg::CMD_RD
                || cmd_code == sdc_pkg::CMD_WR)) begin
            // New access truncates any burst in progress
            state <= (cmd_code == sdc_pkg::CMD_RD) ? sdc_pkg::ST_READ
                : sdc_pkg::ST_WRITE;
            col <= addr[sdc_pkg::COL_W-1:0];
            col_base <= addr[sdc_pkg::COL_W-1:0];
            cur_bank <= bank_sel;
            auto_pre <= addr[sdc_pkg::AP_BIT]
                && burst_length != sdc_pkg::BL_PAGE;
            if (cmd_code == sdc_pkg::CMD_WR && write_burst_select_bit) begin
                burst_left <= 8'h01;
            end else begin
                burst_left <= bl_beats;
            end
        end else if (cmd_live && cmd_code == sdc_pkg::CMD_BST) begin
            state <= sdc_pkg::ST_IDLE;
            burst_left <= 8'h00;
            auto_pre <= 1'b0;
        end else if (state != sdc_pkg::ST_IDLE) begin
            // NOP and inhibit let the burst run on
            if (burst_end) begin
                state <= sdc_pkg::ST_IDLE;
                burst_left <= 8'h00;
                auto_pre <= 1'b0;
            end else begin
                col <= next_col;
                if (bl_beats != 8'h00) begin
                    burst_left <= 8'(burst_left - 8'h01);
                end
            end
        end
    end

    // Terminate always leaves the sequencer idle
    AST_BST_STOP: assert property (cmd_live
        && cmd_code == sdc_pkg::CMD_BST |=> state == sdc_pkg::ST_IDLE)
        else $error("Burst terminate did not stop burst");
    // Gate low keeps the block in self refresh
    AST_SELF_HOLD: assert property (state == sdc_pkg::ST_SELF
        && !clk_gate |=> state == sdc_pkg::ST_SELF)
        else $error("Self refresh left with gate low");

    // ==========================================================
    // Bank row tracking
    generate
        for (genvar b = 0; b < sdc_pkg::BANKS; b++) begin : g_bank
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    banks[b] <= '0;
                end else if (cmd_live && cmd_code == sdc_pkg::CMD_ACT
                        && bank_sel == 2'(b)) begin
                    banks[b].open <= 1'b1;
                    banks[b].row <= addr;
                end else if (cmd_live && cmd_code == sdc_pkg::CMD_PRE
                        && (addr[sdc_pkg::AP_BIT] || bank_sel == 2'(b))) begin
                    banks[b].open <= 1'b0;
                end else if (state != sdc_pkg::ST_IDLE && state != sdc_pkg::ST_SELF
                        && burst_end && auto_pre && cur_bank == 2'(b)
                        && !(cmd_live && (cmd_code == sdc_pkg::CMD_RD
                        || cmd_code == sdc_pkg::CMD_WR
                        || cmd_code == sdc_pkg::CMD_BST))) begin
                    banks[b].open <= 1'b0;
                end
            end
            assign bank_open[b] = banks[b].open;
        end
    endgenerate
    // Activate opens the selected bank on the next edge
    AST_ACT_OPEN: assert property (cmd_live
        && cmd_code == sdc_pkg::CMD_ACT |=> bank_open[$past(bank_sel)])
        else $error("Activated bank not open");

    // ==========================================================
    // Refresh row counter, shared by both refresh kinds
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            refresh_row <= '0;
        end else if ((cmd_live && cmd_code == sdc_pkg::CMD_REF)
                || (!cmd.cs_n && !clk_gate && cmd_code == sdc_pkg::CMD_REF
                && state != sdc_pkg::ST_SELF)) begin
            refresh_row <= AW'(refresh_row + 1'b1);
        end
    end

    // Each auto refresh steps the row counter by one
    AST_REF_STEP: assert property (cmd_live
        && cmd_code == sdc_pkg::CMD_REF
        |=> refresh_row == AW'($past(refresh_row) + 1'b1))
        else $error("Refresh row did not step");

    // ==========================================================
    // Write path: mask sampled with the data, no delay
    always_ff @(posedge core_clk) begin
        if (cmd_live && cmd_code == sdc_pkg::CMD_WR) begin
            for (int l = 0; l < sdc_pkg::LANES; l++) begin
                if (!byte_mask[l]) begin
                    mem[MEM_AW'({bank_sel, banks[bank_sel].row,
                        addr[sdc_pkg::COL_W-1:0]})][l*8 +: 8]
                        <= dq_in[l*8 +: 8];
                end
            end
        end else if (state == sdc_pkg::ST_WRITE && !burst_end
                && !(cmd_live && cmd_code != sdc_pkg::CMD_NOP)) begin
            // Any executed command other than NOP skips the write beat of that cycle
            for (int l = 0; l < sdc_pkg::LANES; l++) begin
                if (!byte_mask[l]) begin
                    mem[MEM_AW'({cur_bank, banks[cur_bank].row,
                        next_col})][l*8 +: 8]
                        <= dq_in[l*8 +: 8];
                end
            end
        end
    end

    // ==========================================================
    // Read pipe: stage k holds beats read k+1 clocks ago
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pipe <= 4'h0;
            mask_d1 <= '1;
            mask_d2 <= '1;
            for (int k = 0; k < 4; k++) begin
                rd_addr_pipe[k] <= '0;
            end
        end else begin
            rd_pipe[0] <= (cmd_live && cmd_code == sdc_pkg::CMD_RD)
                || (state == sdc_pkg::ST_READ && !burst_end
                && !(cmd_live && cmd_code != sdc_pkg::CMD_NOP));
            rd_addr_pipe[0] <= (cmd_live && cmd_code == sdc_pkg::CMD_RD)
                ? MEM_AW'({bank_sel, banks[bank_sel].row, addr[7:0]})
                : MEM_AW'({cur_bank, banks[cur_bank].row, next_col});
            for (int k = 1; k < 4; k++) begin
                rd_pipe[k] <= rd_pipe[k-1];
                rd_addr_pipe[k] <= rd_addr_pipe[k-1];
            end
            mask_d1 <= byte_mask;
            mask_d2 <= mask_d1;
        end
    end

    // Output stage: beat taken at latency minus one, driven after it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_out <= '0;
            dq_oe <= '0;
        end else begin
            logic sel_v;
            logic [MEM_AW-1:0] sel_a;
            sel_v = 1'b0;
            sel_a = '0;
            case (read_latency)
                sdc_pkg::CL_1: begin
                    sel_v = cmd_live && cmd_code == sdc_pkg::CMD_RD;
                    sel_a = MEM_AW'({bank_sel, banks[bank_sel].row, addr[7:0]});
                end
                sdc_pkg::CL_2: begin
                    sel_v = rd_pipe[0];
                    sel_a = rd_addr_pipe[0];
                end
                sdc_pkg::CL_3: begin
                    sel_v = rd_pipe[1];
                    sel_a = rd_addr_pipe[1];
                end
                default: begin
                    sel_v = 1'b0;
                    sel_a = '0;
                end
            endcase
            dq_out <= mem[sel_a];
            for (int l = 0; l < sdc_pkg::LANES; l++) begin
                // Mask seen one edge back, i.e. at the present edge - 1
                dq_oe[l] <= sel_v && !mask_d1[l];
            end
        end
    end
    // Read issued at the given latency setting
    sequence s_read_cmd(logic [2:0] lat);
        cmd_live && cmd_code == sdc_pkg::CMD_RD && read_latency == lat;
    endsequence
    // Lanes driven match the mask seen two edges back
    sequence s_lanes_follow_mask;
        dq_oe == ~$past(byte_mask, 2);
    endsequence
    AST_CL1_FIRST: assert property (s_read_cmd(sdc_pkg::CL_1)
        |=> s_lanes_follow_mask)
        else $error("Latency 1 first beat lanes wrong");
    AST_CL2_FIRST: assert property (s_read_cmd(sdc_pkg::CL_2)
        |-> ##2 s_lanes_follow_mask)
        else $error("Latency 2 first beat lanes wrong");
    AST_CL3_FIRST: assert property (s_read_cmd(sdc_pkg::CL_3)
        |-> ##3 s_lanes_follow_mask)
        else $error("Latency 3 first beat lanes wrong");
    // A lane masked two edges back is never driven
    AST_MASK_BLANK: assert property ((dq_oe & mask_d2) == '0)
        else $error("Masked lane driven");
    // Mode bits other than normal are not acted upon here
endmodule
`default_nettype wire

// ### sdc_pkg.sv
// Purpose: shared constants and types for the synchronous DRAM command block
// Assumes: four banks, 32-bit data, 12-bit address, 8-bit column
// Notes: mode register field positions and command codes live here
package sdc_pkg;
    // ==========================================================
    // Geometry
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int COL_W = 8;
    localparam int BANKS = 4;
    localparam int LANES = 4;
    // ==========================================================
    // Mode register fields
    localparam int MR_BL_LO = 0;
    localparam int MR_BT = 3;
    localparam int MR_CL_LO = 4;
    localparam int MR_OP_LO = 7;
    localparam int MR_WB = 9;
    localparam logic [ADDR_W-1:0] MR_RESET = 12'h020; // CL 2, BL 1
    // Burst length codes
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    // Read latency codes
    localparam logic [2:0] CL_1 = 3'h1;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_3 = 3'h3;
    localparam logic [1:0] OP_NORMAL = 2'h0;
    // Address bit that selects auto precharge / all banks
    localparam int AP_BIT = 10;
    // Byte mask to output latency, clocks
    localparam int MASK_LAT = 2;
    // ==========================================================
    // Commands: {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRL = 4'h0;
    // ==========================================================
    // Types
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sdc_cmd_t;
    typedef struct packed {
        logic open;
        logic [ADDR_W-1:0] row;
    } sdc_bank_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_READ = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_SELF = 4'b1000
    } sdc_state_t;
endpackage

// ### sdc_ctrl_model.sv
// Purpose: memory controller model driving the command and data pins
// Assumes: shares core_clk; pins change on the falling edge
// Notes: timing counts shortened as parameters; idle scrambles buses
`timescale 1ns/1ns
`default_nettype none
module sdc_ctrl_model #(
    parameter int MRD_CLKS = 2, // Mode load time
    parameter int PRE_CLKS = 3, // Precharge time
    parameter int RAS_CLKS = 5, // Row active time
    parameter int XSR_CLKS = 6 // Self refresh exit time
) (
    // Clock
    input wire logic core_clk,
    // Command pins
    output var logic clk_gate,
    output var sdc_pkg::sdc_cmd_t cmd,
    output var logic bank_select_low,
    output var logic bank_select_high,
    output var logic [sdc_pkg::ADDR_W-1:0] addr,
    // Data pins
    output var logic [sdc_pkg::LANES-1:0] byte_mask,
    output var logic [sdc_pkg::DATA_W-1:0] dq_in
);
    // ==========================================================
    // Pin drive
    // Known levels from time zero
    initial begin
        clk_gate = 1'b1;
        cmd = sdc_pkg::CMD_NOP;
        {bank_select_high, bank_select_low} = 2'h0;
        addr = 12'h000;
        byte_mask = 4'h0;
        dq_in = 32'h00000000;
    end
    // One command, held for one edge
    task automatic issue(input logic [3:0] c, input logic [1:0] ba,
        input logic [11:0] a, input logic [3:0] m, input logic [31:0] d,
        input logic ck);
        @(negedge core_clk);
        cmd <= c;
        {bank_select_high, bank_select_low} <= ba;
        addr <= a;
        byte_mask <= m;
        dq_in <= d;
        clk_gate <= ck;
    endtask
    // NOPs; buses toggle so stale values never look valid
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge core_clk);
            cmd <= sdc_pkg::CMD_NOP;
            addr <= ~addr;
            dq_in <= ~dq_in;
        end
    endtask
    // Mode load only with banks idle, normal mode, then wait
    task automatic load_mode(input logic [11:0] op);
        issue(sdc_pkg::CMD_MRL, 2'h0, op, 4'h0, 32'h0, 1'b1);
        idle(MRD_CLKS);
    endtask
    // Self refresh kept for row active time, gate held low
    task automatic enter_self();
        issue(sdc_pkg::CMD_REF, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
        idle(RAS_CLKS);
    endtask
    // Exit: gate high on a running clock, then NOPs
    task automatic exit_self();
        issue(sdc_pkg::CMD_NOP, 2'h0, 12'h000, 4'h0, 32'h0, 1'b1);
        idle(XSR_CLKS);
    endtask
endmodule
`default_nettype wire

// ### sdc_core_tb.sv
// Purpose: self-checking bench for the SDRAM command block
// Assumes: controller model drives every pin input
// Notes: refresh resumes right after self refresh exit
`timescale 1ns/1ns
`default_nettype none
module sdc_core_tb;
    // ==========================================================
    // Signals
    logic core_clk;
    logic rst_n;
    logic clk_gate;
    sdc_pkg::sdc_cmd_t cmd;
    logic bank_select_low;
    logic bank_select_high;
    logic [11:0] addr;
    logic [3:0] byte_mask;
    logic [31:0] dq_in;
    logic [31:0] dq_out;
    logic [3:0] dq_oe;
    logic [3:0] bank_open;
    logic self_refresh_active;
    logic [11:0] refresh_row;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    // ==========================================================
    // Instances
    sdc_core sdc_core_i (.core_clk(core_clk), .rst_n(rst_n),
        .clk_gate(clk_gate), .cmd(cmd), .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high), .addr(addr),
        .byte_mask(byte_mask), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .bank_open(bank_open),
        .self_refresh_active(self_refresh_active),
        .refresh_row(refresh_row));
    sdc_ctrl_model sdc_ctrl_model_i (.core_clk(core_clk),
        .clk_gate(clk_gate), .cmd(cmd), .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high), .addr(addr),
        .byte_mask(byte_mask), .dq_in(dq_in));
    // 50 MHz clock
    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;
    // ==========================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Command that keeps the present mask, data and gate levels
    task automatic op(input logic [3:0] c, input logic [1:0] ba,
        input logic [11:0] a);
        sdc_ctrl_model_i.issue(c, ba, a, byte_mask, dq_in, clk_gate);
    endtask
    // Read with mask set one edge early so CL 1 sees it too
    task automatic rd(input logic [11:0] a, input logic [3:0] m,
        input int cl, input logic [31:0] exp);
        logic [31:0] lm;
        logic [3:0] oe;
        lm = {{8{~m[3]}}, {8{~m[2]}}, {8{~m[1]}}, {8{~m[0]}}};
        oe = ~m;
        sdc_ctrl_model_i.issue(sdc_pkg::CMD_NOP, 2'h1, a, m, 32'h0, 1'b1);
        sdc_ctrl_model_i.issue(sdc_pkg::CMD_RD, 2'h1, a, m, 32'h0, 1'b1);
        if (cl > 1) begin
            sdc_ctrl_model_i.idle(cl - 1);
            chk(dq_oe, 4'h0);
        end
        sdc_ctrl_model_i.idle(1);
        chk(dq_oe, oe);
        chk(dq_out & lm, exp & lm);
    endtask
    // ==========================================================
    // Scenarios
    // Each latency: full write, masked write, masked read back
    task automatic t_latency();
        logic [31:0] d0;
        logic [31:0] d1;
        for (int cl = 1; cl <= 3; cl++) begin
            d0 = 32'h3c2d1e0f ^ cl;
            d1 = 32'ha5b6c7d8 ^ (cl << 8);
            sdc_ctrl_model_i.load_mode(12'(cl << 4));
            op(sdc_pkg::CMD_ACT, 2'h1, 12'h005);
            sdc_ctrl_model_i.idle(2);
            sdc_ctrl_model_i.issue(sdc_pkg::CMD_WR, 2'h1, 12'h003, 4'h0,
                d0, 1'b1);
            sdc_ctrl_model_i.idle(2);
            sdc_ctrl_model_i.issue(sdc_pkg::CMD_WR, 2'h1, 12'h003, 4'h2,
                d1, 1'b1);
            sdc_ctrl_model_i.idle(2);
            rd(12'h003, 4'h5, cl, {d1[31:16], d0[15:8], d1[7:0]});
            sdc_ctrl_model_i.idle(3);
            op(sdc_pkg::CMD_PRE, 2'h0, 12'h400);
            sdc_ctrl_model_i.idle(3);
        end
        $display("t_latency done");
    endtask
    // Open three banks, close one, then all
    task automatic t_banks();
        op(sdc_pkg::CMD_ACT, 2'h0, 12'h011);
        op(sdc_pkg::CMD_ACT, 2'h2, 12'h022);
        op(sdc_pkg::CMD_ACT, 2'h3, 12'h033);
        sdc_ctrl_model_i.idle(1);
        chk(bank_open, 4'hd);
        op(sdc_pkg::CMD_PRE, 2'h2, 12'h000);
        sdc_ctrl_model_i.idle(3);
        chk(bank_open, 4'h9);
        op(sdc_pkg::CMD_PRE, 2'h1, 12'h400);
        sdc_ctrl_model_i.idle(3);
        chk(bank_open, 4'h0);
        $display("t_banks done");
    endtask
    // Auto precharge, plain read, terminate and inhibit mid burst
    task automatic t_burst();
        sdc_ctrl_model_i.load_mode(12'h020);
        for (int ap = 1; ap >= 0; ap--) begin
            op(sdc_pkg::CMD_ACT, 2'h2, 12'h007);
            sdc_ctrl_model_i.idle(2);
            sdc_ctrl_model_i.issue(sdc_pkg::CMD_RD, 2'h2, 12'(ap << 10),
                4'h0, 32'h0, 1'b1);
            sdc_ctrl_model_i.idle(6);
            chk(bank_open, ap ? 4'h0 : 4'h4);
        end
        op(sdc_pkg::CMD_PRE, 2'h0, 12'h400);
        sdc_ctrl_model_i.idle(3);
        sdc_ctrl_model_i.load_mode(12'h023);
        op(sdc_pkg::CMD_ACT, 2'h0, 12'h001);
        sdc_ctrl_model_i.idle(2);
        for (int k = 0; k < 2; k++) begin
            sdc_ctrl_model_i.issue(sdc_pkg::CMD_RD, 2'h0, 12'h000, 4'h0,
                32'h0, 1'b1);
            sdc_ctrl_model_i.idle(2);
            op(k ? 4'h8 : sdc_pkg::CMD_BST, 2'h0, 12'h000);
            sdc_ctrl_model_i.idle(3);
            chk(dq_oe, k ? 4'hf : 4'h0);
            chk(bank_open, 4'h1);
            sdc_ctrl_model_i.idle(6);
        end
        op(sdc_pkg::CMD_PRE, 2'h0, 12'h400);
        sdc_ctrl_model_i.idle(3);
        $display("t_burst done");
    endtask
    // Refresh counter, self refresh ignores commands, exit, resume
    task automatic t_refresh();
        logic [11:0] r0;
        for (int k = 0; k < 2; k++) begin
            r0 = refresh_row;
            op(sdc_pkg::CMD_REF, 2'h3, 12'hfff);
            sdc_ctrl_model_i.idle(4);
            chk(refresh_row, r0 + 12'h001);
            if (k == 0) begin
                sdc_ctrl_model_i.issue(sdc_pkg::CMD_REF, 2'h0, 12'h000,
                    4'h0, 32'h0, 1'b0);
                sdc_ctrl_model_i.idle(2);
                chk(self_refresh_active, 1'b1);
                op(sdc_pkg::CMD_ACT, 2'h1, 12'h000);
                sdc_ctrl_model_i.idle(4);
                chk(bank_open, 4'h0);
                sdc_ctrl_model_i.exit_self();
                chk(self_refresh_active, 1'b0);
            end
        end
        $display("t_refresh done");
    endtask
    // ==========================================================
    // Verdict and hang guard
    task automatic print_verdict();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Run is under two hundred cycles; far past that means a hang
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            print_verdict();
        end
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        t_latency();
        t_banks();
        t_burst();
        t_refresh();
        print_verdict();
    end
endmodule
`default_nettype wire
